//--- bench/dsu_host_model.sv
// host serial port model driving frame select, shift clock and data
// assumes the bench clock at 4 ns; shift clock half period is 20 clocks
`timescale 1ns/1ps
module dsu_host_model (
  input  wire logic clk_i,
  input  wire logic ser_out_i,
  input  wire logic ser_oe_i,
  output logic      fs_n_o,
  output logic      sclk_o,
  output logic      ser_in_o
);
  // ==========================================
  // idle pins
  // shift clock stands low between frames
  initial begin
    fs_n_o = 1'b1;
    sclk_o = 1'b0;
    ser_in_o = 1'b0;
  end

  task automatic half();
    repeat (20) @(negedge clk_i);
  endtask

  // ==========================================
  // one frame of n clocks
  // gated burst, exact count
  task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] rx,
                      output logic oe_all);
    rx = '0;
    oe_all = 1'b1;
    @(negedge clk_i);
    fs_n_o = 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      // msb first, set before the fall
      ser_in_o = w[i];
      sclk_o = 1'b1;
      half();
      // serial out taken at the fall
      sclk_o = 1'b0;
      rx = {rx[46:0], ser_out_i};
      oe_all = oe_all & ser_oe_i;
      half();
    end
    // frame select raised after the last edge
    fs_n_o = 1'b1;
    // released data line must not keep its last value
    ser_in_o = ~ser_in_o;
    half();
  endtask
endmodule

//--- bench/dual_dac_serial_update_control_test.sv
// self-checking bench of the serial update block against a frame model
// assumes the host model drives the link pins; strobe driven here
`timescale 1ns/1ps
module dual_dac_serial_update_control_test;
  import dsu_pkg::*;
  logic        clk;
  logic        rst;
  logic        load_strobe_n;
  logic        fs_n;
  logic        sclk;
  logic        ser_in;
  logic        ser_out;
  logic        ser_oe;
  logic [11:0] cha_dac;
  logic [11:0] chb_dac;
  logic [1:0]  cha_pwr;
  logic [1:0]  chb_pwr;
  logic [23:0] sr;
  logic [47:0] rx;
  logic [47:0] w1;
  logic [47:0] w2;
  logic        oe_all;
  logic [3:0]  adrs [4] = '{4'h1, 4'h8, 4'h9, 4'h0};
  int failures = 0;
  int checks = 0;
  int seed = 32'h43b0;
  int ina = 0, inb = 0, daca = 0, dacb = 0, pa = 0, pb = 0;
  int mask = 0, chain = 0, rbpend = 0, rbsel = 0;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  dsu_host_model host (.clk_i(clk), .ser_out_i(ser_out), .ser_oe_i(ser_oe), .fs_n_o(fs_n),
                       .sclk_o(sclk), .ser_in_o(ser_in));
  dsu_top dut (.CLK_I(clk), .RST_I(rst), .FRAME_SEL_N_I(fs_n), .SHIFT_CLK_I(sclk),
               .SERIAL_IN_I(ser_in), .LOAD_STROBE_N_I(load_strobe_n), .SERIAL_OUT_O(ser_out),
               .SERIAL_OUT_OE_O(ser_oe), .CHA_DAC_O(cha_dac), .CHB_DAC_O(chb_dac),
               .CHA_POWER_O(cha_pwr), .CHB_POWER_O(chb_pwr));

  // ==========================================
  // comparison and verdict
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check_outs();
    chk(24'(cha_dac), 24'(daca));
    chk(24'(chb_dac), 24'(dacb));
    chk(24'(cha_pwr), 24'(pa));
    chk(24'(chb_pwr), 24'(pb));
    chk(24'(ser_oe), 24'(chain));
  endtask

  function automatic logic [47:0] w24(input logic [3:0] c, input logic [3:0] a,
                                      input logic [11:0] d);
    return {24'h0, c, a, d, 4'h0};
  endfunction

  // ==========================================
  // frame model: last bits before frame select rise count
  task automatic frame(input logic [47:0] w, input int n);
    logic [3:0] cmd;
    logic [3:0] adr;
    logic       wr;
    host.xfer(w, n, rx, oe_all);
    if (rbpend != 0) begin
      chk(24'(oe_all), 24'h1);
      chk(24'(rx[19:8]), 24'(rbsel != 0 ? dacb : daca));
    end
    for (int i = n - 1; i >= 0; i--) sr = {sr[22:0], w[i]};
    cmd = sr[23:20];
    adr = sr[19:16];
    wr = (cmd == 4'h1) || (cmd == 4'h3);
    rbpend = 0;
    if (wr && adr[0]) ina = sr[15:4];
    if (wr && adr[3]) inb = sr[15:4];
    if (adr[0] && (cmd == 4'h2 || cmd == 4'h3 || (cmd == 4'h1 && !load_strobe_n))) daca = ina;
    if (adr[3] && (cmd == 4'h2 || cmd == 4'h3 || (cmd == 4'h1 && !load_strobe_n))) dacb = inb;
    if (cmd == 4'h4) pa = sr[1:0];
    if (cmd == 4'h4) pb = sr[7:6];
    if (cmd == 4'h5) mask = sr[3:0];
    if (cmd == 4'h8) chain = sr[0];
    if (cmd == 4'h9) rbpend = 1;
    if (cmd == 4'h9) rbsel = (adr == 4'h8);
    check_outs();
  endtask

  task automatic strobe();
    @(negedge clk);
    load_strobe_n = 1'b0;
    repeat (10) @(negedge clk);
    load_strobe_n = 1'b1;
    repeat (10) @(negedge clk);
    if (!mask[0]) daca = ina;
    if (!mask[3]) dacb = inb;
    check_outs();
  endtask

  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    load_strobe_n = 1'b1;
    sr = '0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    check_outs();
    chk(24'(ser_out), 24'h0);
    for (int k = 0; k < 3; k++) frame(w24(4'h3, adrs[k], 12'($random(seed))), 24);
    frame(w24(4'h1, 4'h9, 12'($random(seed))), 24);
    strobe();
    frame(48'h500009, 24);
    // masked channels see no copy on this fall
    load_strobe_n = 1'b0;
    frame(w24(4'h1, 4'h9, 12'($random(seed))), 24);
    load_strobe_n = 1'b1;
    frame(48'h500008, 24);
    frame(w24(4'h1, 4'h9, 12'($random(seed))), 24);
    strobe();
    frame(48'h500000, 24);
    frame(w24(4'h1, 4'h9, 12'($random(seed))), 24);
    frame(48'h290000, 24);
    for (int c = 0; c < 4; c++) frame({24'h0, 16'h4000, 2'(c), 4'hf, 2'(3 - c)}, 24);
    frame(w24(4'h3, 4'h8, 12'($random(seed))), 24);
    frame(48'h40003c, 24);
    frame(48'h000031, 24);
    frame(48'h005670, 16);
    for (int k = 0; k < 4; k++) begin
      frame(w24(4'h9, adrs[k], 12'($random(seed))), 24);
      frame(48'h0, 24);
    end
    frame(48'h800001, 24);
    w1 = w24(4'h3, 4'h1, 12'($random(seed)));
    w2 = w24(4'h3, 4'h8, 12'($random(seed)));
    frame({w1[23:0], w2[23:0]}, 48);
    chk(rx[23:0], w1[23:0]);
    chk(rx[47:24], 24'h800001);
    frame(48'h800000, 24);
    complete_run();
  end

  // ==========================================
  // watchdog, about two and a half times the expected run of some 31k clocks
  initial begin
    #300000;
    failures++;
    complete_run();
  end
endmodule

//--- common/dsu_map.svh
// offsets, field positions, command codes and reset values of the
// dual converter serial update block; included wherever a macro is used
`ifndef DSU_MAP_SVH
`define DSU_MAP_SVH

// ==========================================
// frame layout
`define DSU_FRAME_BITS   24
`define DSU_CNT_W        5
`define DSU_CMD_MSB      23
`define DSU_CMD_LSB      20
`define DSU_ADDR_MSB     19
`define DSU_ADDR_LSB     16
`define DSU_DATA_MSB     15
`define DSU_DATA_LSB     4
`define DSU_DATA_W       12
`define DSU_RB_PAD       4'h0

// ==========================================
// command codes
`define DSU_CMD_WR_IN    4'h1
`define DSU_CMD_UPD      4'h2
`define DSU_CMD_WR_UPD   4'h3
`define DSU_CMD_PWR      4'h4
`define DSU_CMD_MASK     4'h5
`define DSU_CMD_CHAIN    4'h8
`define DSU_CMD_RB       4'h9

// ==========================================
// field positions
`define DSU_ADDR_B_BIT   3
`define DSU_ADDR_A_BIT   0
`define DSU_ADDR_B_ONLY  4'h8
`define DSU_PWR_B_HI     7
`define DSU_PWR_B_LO     6
`define DSU_PWR_A_HI     1
`define DSU_PWR_A_LO     0
`define DSU_MASK_MSB     3
`define DSU_MASK_B_BIT   3
`define DSU_MASK_A_BIT   0
`define DSU_CHAIN_BIT    0

// ==========================================
// reset values
`define DSU_MASK_RST     4'h0
`define DSU_PWR_RST      2'h0
`define DSU_CHAIN_RST    1'b0
`define DSU_DAC_RST      12'h000

`endif

//--- common/dsu_pkg.sv
// types of the dual converter serial update block
// assumes the map header sits beside it on the include path
package dsu_pkg;
  `include "dsu_map.svh"

  // ==========================================
  // frame sequencer, gray coded along idle->frame->exec
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FRAME = 2'b01,
    ST_EXEC  = 2'b11
  } dsu_state_t;

  // ==========================================
  // complete state of the top module
  typedef struct packed {
    dsu_state_t                   state;
    logic [`DSU_FRAME_BITS-1:0]   shift;
    logic [`DSU_CNT_W-1:0]        bit_count;
    logic                         sout;
    logic                         sout_oe;
    logic                         chain_enable;
    logic                         rb_pend;
    logic                         rb_sel_b;
    logic                         rb_active;
    logic [1:0]                   cha_power;
    logic [1:0]                   chb_power;
    logic [`DSU_MASK_MSB:0]       mask;
  } dsu_top_st_t;
endpackage

//--- src/dsu_chan.sv
// one channel: input register and converter register pair
// assumes strobes are single-cycle pulses on CLK_I
`timescale 1ns/1ps
`include "dsu_map.svh"
module dsu_chan #(
  parameter int DW = 12
) (
  input  wire logic          CLK_I,
  input  wire logic          RST_I,
  input  wire logic          wr_input_i,
  input  wire logic          wr_dac_i,
  input  wire logic          copy_i,
  input  wire logic [DW-1:0] data_i,
  output logic      [DW-1:0] input_reg_o,
  output logic      [DW-1:0] dac_reg_o
);
  typedef struct packed {
    logic [DW-1:0] in_reg;
    logic [DW-1:0] dac;
  } dsu_chan_st_t;

  dsu_chan_st_t st;
  dsu_chan_st_t next_st;

  // ==========================================
  // direct write beats copy; a copy in the same cycle as
  // an input write moves the older input value
  always_comb begin
    next_st = st;
    if (wr_input_i) begin
      next_st.in_reg = data_i;
    end
    if (wr_dac_i) begin
      next_st.dac = data_i;
    end else if (copy_i) begin
      next_st.dac = st.in_reg;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st <= {DW'(`DSU_DAC_RST), DW'(`DSU_DAC_RST)};
    end else begin
      st <= next_st;
    end
  end

  assign input_reg_o = st.in_reg;
  assign dac_reg_o   = st.dac;
endmodule

//--- src/dsu_sync.sv
// two-stage synchroniser with a third stage for edge finding
// assumes inputs come from outside the CLK_I domain
`timescale 1ns/1ps
module dsu_sync #(
  parameter int W = 4
) (
  input  wire logic         CLK_I,
  input  wire logic         RST_I,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o,
  output logic      [W-1:0] q_d_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } dsu_sync_st_t;

  dsu_sync_st_t st;
  dsu_sync_st_t next_st;

  // ==========================================
  // stage one feeds stage two only
  always_comb begin
    next_st    = st;
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_o   = st.s2;
  assign q_d_o = st.s3;
endmodule

//--- src/dsu_top.sv
// serial command and update logic of a dual voltage-output converter
// assumes frame select, shift clock, data and load strobe are pins
// from the host, asynchronous to CLK_I and much slower than it
//
// Function
// - frame low: shift every clock, overflow out
// - serial out changes on rising clock
// - short or long frames still execute
// - frame select rise latches, stops shifting
// - command 1001 picks channel to read back
// - readback drives output even if unchained
// - ambiguous readback address returns channel A
// - next frame shifts out readback word
// - command 0100 sets both power fields
// - power field selects output mode
// - powered-down channel keeps and accepts data
// - strobe low: write input and converter
// - strobe high: input only, fall copies
// - command 0101 loads strobe mask, reset zero
// - masked channel ignores strobe fall
// - strobe fall copies unmasked channels
// - strobe tied low ignores mask
// - command 0010 copies input to converter
// - command 0011 writes both registers
// - 24 bits, msb first, falling edge sampled
// - address msb channel B, lsb A
// - command 1000 sets chain enable
`timescale 1ns/1ps
`include "dsu_map.svh"
module dsu_top
  import dsu_pkg::*;
#(
  parameter int DW = `DSU_DATA_W
) (
  input  wire logic          CLK_I,
  input  wire logic          RST_I,
  input  wire logic          FRAME_SEL_N_I,
  input  wire logic          SHIFT_CLK_I,
  input  wire logic          SERIAL_IN_I,
  input  wire logic          LOAD_STROBE_N_I,
  output logic               SERIAL_OUT_O,
  output logic               SERIAL_OUT_OE_O,
  output logic      [DW-1:0] CHA_DAC_O,
  output logic      [DW-1:0] CHB_DAC_O,
  output logic      [1:0]    CHA_POWER_O,
  output logic      [1:0]    CHB_POWER_O
);

  // ==========================================
  // pin lanes of the synchroniser
  localparam int LN_FS = 3;
  localparam int LN_CK = 2;
  localparam int LN_DI = 1;
  localparam int LN_LD = 0;
  localparam logic [`DSU_CNT_W-1:0] CNT_MAX = '1;

  localparam dsu_top_st_t ST_RESET = '{
    state:        ST_IDLE,
    shift:        '0,
    bit_count:    '0,
    sout:         1'b0,
    sout_oe:      `DSU_CHAIN_RST,
    chain_enable: `DSU_CHAIN_RST,
    rb_pend:      1'b0,
    rb_sel_b:     1'b0,
    rb_active:    1'b0,
    cha_power:    `DSU_PWR_RST,
    chb_power:    `DSU_PWR_RST,
    mask:         `DSU_MASK_RST
  };

  dsu_top_st_t st;
  dsu_top_st_t next_st;

  logic [3:0]    pin_q;
  logic [3:0]    pin_q_d;
  logic          fs_fall;
  logic          fs_rise;
  logic          ck_fall;
  logic          ck_rise;
  logic          ld_fall;
  logic          ld_low;
  logic          exec;
  logic [3:0]    cmd;
  logic [3:0]    addr;
  logic [DW-1:0] data;
  logic [1:0]    wr_input;
  logic [1:0]    wr_dac;
  logic [1:0]    copy;
  logic [DW-1:0] in_reg [2];
  logic [DW-1:0] dac_reg [2];

  // ==========================================
  // decode helpers
  // channel 0 is A, channel 1 is B
  function automatic logic addr_hit(input logic [3:0] a, input int ch);
    addr_hit = (ch == 0) ? a[`DSU_ADDR_A_BIT] : a[`DSU_ADDR_B_BIT];
  endfunction

  function automatic logic mask_bit(input logic [3:0] m, input int ch);
    mask_bit = (ch == 0) ? m[`DSU_MASK_A_BIT] : m[`DSU_MASK_B_BIT];
  endfunction

  // ==========================================
  // pin synchronisers
  dsu_sync #(
    .W (4)
  ) u_sync (
    .CLK_I (CLK_I),
    .RST_I (RST_I),
    .d_i   ({FRAME_SEL_N_I, SHIFT_CLK_I, SERIAL_IN_I, LOAD_STROBE_N_I}),
    .q_o   (pin_q),
    .q_d_o (pin_q_d)
  );

  // data lane shares the clock lane's delay, so the sampled bit
  // is the level seen at the falling clock edge
  assign fs_fall = pin_q_d[LN_FS] & ~pin_q[LN_FS];
  assign fs_rise = ~pin_q_d[LN_FS] & pin_q[LN_FS];
  assign ck_fall = pin_q_d[LN_CK] & ~pin_q[LN_CK];
  assign ck_rise = ~pin_q_d[LN_CK] & pin_q[LN_CK];
  assign ld_fall = pin_q_d[LN_LD] & ~pin_q[LN_LD];
  assign ld_low  = ~pin_q[LN_LD];

  // ==========================================
  // latched frame fields
  assign exec = (st.state == ST_EXEC);
  assign cmd  = st.shift[`DSU_CMD_MSB:`DSU_CMD_LSB];
  assign addr = st.shift[`DSU_ADDR_MSB:`DSU_ADDR_LSB];
  assign data = st.shift[`DSU_DATA_MSB:`DSU_DATA_LSB];

  // ==========================================
  // frame sequencer and control registers
  always_comb begin
    next_st = st;
    unique case (st.state)
      ST_IDLE: begin
        if (fs_fall) begin
          next_st.state     = ST_FRAME;
          next_st.bit_count = '0;
          if (st.rb_pend) begin
            next_st.shift     = {`DSU_RB_PAD,
                                 st.rb_sel_b ? dac_reg[1] : dac_reg[0],
                                 8'h00};
            next_st.rb_pend   = 1'b0;
            next_st.rb_active = 1'b1;
          end
        end
      end
      ST_FRAME: begin
        if (fs_rise) begin
          next_st.state = ST_EXEC;
        end else begin
          if (ck_fall) begin
            next_st.shift = {st.shift[`DSU_FRAME_BITS-2:0], pin_q[LN_DI]};
            if (st.bit_count != CNT_MAX) begin
              next_st.bit_count = st.bit_count + 1'b1;
            end
          end
          if (ck_rise) begin
            next_st.sout = st.shift[`DSU_FRAME_BITS-1];
          end
        end
      end
      ST_EXEC: begin
        next_st.state     = ST_IDLE;
        next_st.rb_active = 1'b0;
        unique case (cmd)
          `DSU_CMD_PWR: begin
            next_st.cha_power = st.shift[`DSU_PWR_A_HI:`DSU_PWR_A_LO];
            next_st.chb_power = st.shift[`DSU_PWR_B_HI:`DSU_PWR_B_LO];
          end
          `DSU_CMD_MASK: begin
            next_st.mask = st.shift[`DSU_MASK_MSB:0];
          end
          `DSU_CMD_CHAIN: begin
            next_st.chain_enable = st.shift[`DSU_CHAIN_BIT];
          end
          `DSU_CMD_RB: begin
            // only a lone B bit picks B
            next_st.rb_pend  = 1'b1;
            next_st.rb_sel_b = (addr == `DSU_ADDR_B_ONLY);
          end
          default: begin
            next_st.rb_pend = st.rb_pend;
          end
        endcase
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase
    next_st.sout_oe = next_st.chain_enable | next_st.rb_active;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // channel strobes
  // power mode never gates register writes
  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic hit;
    assign hit = exec & addr_hit(addr, i);
    assign wr_input[i] = hit & ((cmd == `DSU_CMD_WR_IN) | (cmd == `DSU_CMD_WR_UPD));
    assign wr_dac[i]   = hit & ((cmd == `DSU_CMD_WR_UPD) |
                                ((cmd == `DSU_CMD_WR_IN) & ld_low));
    assign copy[i] = (hit & (cmd == `DSU_CMD_UPD)) |
                     (ld_fall & ~mask_bit(st.mask, i));

    dsu_chan #(
      .DW (DW)
    ) u_chan (
      .CLK_I       (CLK_I),
      .RST_I       (RST_I),
      .wr_input_i  (wr_input[i]),
      .wr_dac_i    (wr_dac[i]),
      .copy_i      (copy[i]),
      .data_i      (data),
      .input_reg_o (in_reg[i]),
      .dac_reg_o   (dac_reg[i])
    );
  end

  // ==========================================
  // outputs
  assign SERIAL_OUT_O    = st.sout;
  assign SERIAL_OUT_OE_O = st.sout_oe;
  assign CHA_DAC_O       = dac_reg[0];
  assign CHB_DAC_O       = dac_reg[1];
  assign CHA_POWER_O     = st.cha_power;
  assign CHB_POWER_O     = st.chb_power;

  // ==========================================
  // assertions
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  a_frame_start: assert property (
    (st.state == ST_IDLE) && fs_fall |=> (st.state == ST_FRAME) && (st.bit_count == '0)
  ) else $error("frame start did not clear bit count");

  a_shift_in: assert property (
    (st.state == ST_FRAME) && !fs_rise && ck_fall
    |=> st.shift == {$past(st.shift[`DSU_FRAME_BITS-2:0]), $past(pin_q[LN_DI])}
  ) else $error("serial bit not shifted in");

  a_latch_hold: assert property (
    (st.state == ST_IDLE) && !fs_fall |=> $stable(st.shift)
  ) else $error("shift register moved outside frame");

  a_sdo_rise: assert property (
    (st.state == ST_FRAME) && !fs_rise && ck_rise
    |=> SERIAL_OUT_O == $past(st.shift[`DSU_FRAME_BITS-1])
  ) else $error("serial out not updated on rising edge");

  a_rb_drive: assert property (
    (st.state == ST_IDLE) && fs_fall && st.rb_pend |=> ##1 SERIAL_OUT_OE_O
  ) else $error("readback frame left serial out undriven");

  a_rb_default: assert property (
    exec && (cmd == `DSU_CMD_RB) && (addr != `DSU_ADDR_B_ONLY) |=> !st.rb_sel_b && st.rb_pend
  ) else $error("readback did not default to channel A");

  a_power_set: assert property (
    exec && (cmd == `DSU_CMD_PWR)
    |=> CHA_POWER_O == $past(st.shift[1:0]) && CHB_POWER_O == $past(st.shift[7:6])
  ) else $error("power fields not loaded");

  a_mask_load: assert property (
    exec && (cmd == `DSU_CMD_MASK) |=> st.mask == $past(st.shift[3:0])
  ) else $error("strobe mask not loaded");

  a_strobe_copy: assert property (
    ld_fall && !st.mask[`DSU_MASK_A_BIT] && !exec |=> CHA_DAC_O == $past(in_reg[0])
  ) else $error("strobe fall did not copy channel A");

  a_mask_block: assert property (
    ld_fall && st.mask[`DSU_MASK_B_BIT] && !exec |=> $stable(CHB_DAC_O)
  ) else $error("masked channel B followed strobe");

  a_cmd_update: assert property (
    exec && (cmd == `DSU_CMD_UPD) && addr[`DSU_ADDR_B_BIT]
    |=> CHB_DAC_O == $past(in_reg[1]) ##1 ($stable(CHB_DAC_O) || ld_fall)
  ) else $error("update command did not copy channel B");

  a_write_both: assert property (
    exec && (cmd == `DSU_CMD_WR_UPD) && addr[`DSU_ADDR_A_BIT]
    |=> CHA_DAC_O == $past(data) && in_reg[0] == $past(data)
  ) else $error("write-and-update missed a register");

  a_write_thru: assert property (
    exec && (cmd == `DSU_CMD_WR_IN) && addr[`DSU_ADDR_A_BIT] && ld_low
    |=> CHA_DAC_O == $past(data)
  ) else $error("low strobe did not write through");

  a_write_defer: assert property (
    exec && (cmd == `DSU_CMD_WR_IN) && addr[`DSU_ADDR_B_BIT] && !ld_low && !ld_fall
    |=> $stable(CHB_DAC_O) && in_reg[1] == $past(data)
  ) else $error("high strobe wrote the converter register");

endmodule
